// ---- inc/wdcl_params.svh ----
`ifndef WDCL_PARAMS_SVH
`define WDCL_PARAMS_SVH
`define WDCL_CNT_W 8
`define WDCL_CNT_RST 8'h00
`define WDCL_CNT_ONE 8'h01
`define WDCL_FLAG_RST 1'b0
`endif

// ---- inc/wdcl_pkg.sv ----
package wdcl_pkg;
	typedef enum logic [1:0]
	{
		WDCL_OP_NONE = 2'b00,
		WDCL_OP_SINGLE = 2'b01,
		WDCL_OP_FIRST = 2'b10,
		WDCL_OP_SECOND = 2'b11
	} wdcl_op_e;

	typedef enum logic [1:0]
	{
		WDCL_LAST_NONE = 2'b00,
		WDCL_LAST_FIRST = 2'b01,
		WDCL_LAST_SECOND = 2'b10
	} wdcl_last_e;

	typedef struct packed
	{
		logic valid;
		wdcl_op_e op;
	} wdcl_cmd_s;
endpackage : wdcl_pkg

// ---- src/wdcl_clear_logic.sv ----
`timescale 1ns/1ps
`include "wdcl_params.svh"

module wdcl_clear_logic
(
	input wire logic clk,
	input wire logic resetn,
	input wdcl_pkg::wdcl_cmd_s cmd,
	input wire logic count_tick,
	input wire logic timeout_set,
	input wire logic powerdown_set,
	output logic [`WDCL_CNT_W-1:0] watchdog_counter_r,
	output logic timeout_flag_r,
	output logic powerdown_flag_r,
	output logic clear_done_r
);
	import wdcl_pkg::*;

	wdcl_last_e last_r;
	wdcl_last_e last_nxt;
	logic clear_nxt;
	logic is_single;
	logic is_first;
	logic is_second;

	assign is_single = cmd.valid && (cmd.op == WDCL_OP_SINGLE);
	assign is_first = cmd.valid && (cmd.op == WDCL_OP_FIRST);
	assign is_second = cmd.valid && (cmd.op == WDCL_OP_SECOND);

	// decide whether this cycle's op clears
	always_comb
	begin
		clear_nxt = is_single;
		if (is_first && last_r == WDCL_LAST_SECOND)
		begin
			clear_nxt = 1'b1;
		end
		if (is_second && last_r == WDCL_LAST_FIRST)
		begin
			clear_nxt = 1'b1;
		end
	end

	// tracker of the last half-clear
	always_comb
	begin
		last_nxt = last_r;
		if (is_first)
		begin
			last_nxt = WDCL_LAST_FIRST;
		end
		else if (is_second)
		begin
			last_nxt = WDCL_LAST_SECOND;
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			last_r <= WDCL_LAST_NONE;
		end
		else
		begin
			last_r <= last_nxt;
		end
	end

	// counter: clear beats tick; repeated halves leave it counting
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			watchdog_counter_r <= `WDCL_CNT_RST;
		end
		else if (clear_nxt)
		begin
			watchdog_counter_r <= `WDCL_CNT_RST;
		end
		else if (count_tick)
		begin
			watchdog_counter_r <= watchdog_counter_r + `WDCL_CNT_ONE;
		end
	end

	// flags: a set in the clearing cycle wins
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			timeout_flag_r <= `WDCL_FLAG_RST;
			powerdown_flag_r <= `WDCL_FLAG_RST;
		end
		else
		begin
			if (timeout_set)
			begin
				timeout_flag_r <= 1'b1;
			end
			else if (clear_nxt)
			begin
				timeout_flag_r <= 1'b0;
			end
			if (powerdown_set)
			begin
				powerdown_flag_r <= 1'b1;
			end
			else if (clear_nxt)
			begin
				powerdown_flag_r <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			clear_done_r <= 1'b0;
		end
		else
		begin
			clear_done_r <= clear_nxt;
		end
	end

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);

	AST_CLEAR_EFFECT: assert property (
		clear_done_r |-> watchdog_counter_r == `WDCL_CNT_RST
			&& (timeout_flag_r == $past(timeout_set))
			&& (powerdown_flag_r == $past(powerdown_set)))
		else $error("clear did not reset counter and flags");

	AST_FIRST_AFTER_SECOND: assert property (
		(cmd.valid && cmd.op == WDCL_OP_SECOND) ##1 (cmd.valid && cmd.op == WDCL_OP_FIRST)
			|=> clear_done_r)
		else $error("first half after second did not clear");

	AST_SECOND_AFTER_FIRST: assert property (
		(cmd.valid && cmd.op == WDCL_OP_FIRST) ##1 (cmd.valid && cmd.op == WDCL_OP_SECOND)
			|=> clear_done_r)
		else $error("second half after first did not clear");

	AST_REPEAT_FIRST: assert property (
		(last_r == WDCL_LAST_FIRST && is_first && !is_single) |=> !clear_done_r)
		else $error("repeated first half cleared");

	AST_REPEAT_SECOND: assert property (
		(last_r == WDCL_LAST_SECOND && is_second) |=> !clear_done_r)
		else $error("repeated second half cleared");

	AST_REPEAT_KEEPS_FLAG: assert property (
		(last_r == WDCL_LAST_FIRST && is_first && timeout_flag_r) |=> timeout_flag_r)
		else $error("ignored half-clear touched timeout flag");

	AST_SINGLE: assert property (
		is_single |=> clear_done_r && watchdog_counter_r == `WDCL_CNT_RST)
		else $error("single clear did not act");

	AST_TRACK: assert property (
		is_second |=> last_r == WDCL_LAST_SECOND)
		else $error("tracker lost second half");

	AST_NO_CLEAR_IDLE: assert property (
		!cmd.valid |=> !clear_done_r)
		else $error("clear with no command");

	AST_REPEAT_FIRST_COUNT: assert property (
		(last_r == WDCL_LAST_FIRST && is_first)
			|=> watchdog_counter_r == $past(watchdog_counter_r)
				+ ($past(count_tick) ? `WDCL_CNT_ONE : `WDCL_CNT_RST))
		else $error("ignored first half touched counter");

	AST_REPEAT_SECOND_COUNT: assert property (
		(last_r == WDCL_LAST_SECOND && is_second)
			|=> watchdog_counter_r == $past(watchdog_counter_r)
				+ ($past(count_tick) ? `WDCL_CNT_ONE : `WDCL_CNT_RST))
		else $error("ignored second half touched counter");

	AST_REPEAT_FIRST_POWERDOWN: assert property (
		(last_r == WDCL_LAST_FIRST && is_first && powerdown_flag_r)
			|=> powerdown_flag_r)
		else $error("ignored first half touched powerdown flag");

	AST_REPEAT_SECOND_FLAGS: assert property (
		(last_r == WDCL_LAST_SECOND && is_second && (timeout_flag_r || powerdown_flag_r))
			|=> (timeout_flag_r || $past(!timeout_flag_r)) && (powerdown_flag_r || $past(!powerdown_flag_r)))
		else $error("ignored second half touched a flag");

	AST_SINGLE_KEEPS_TRACK: assert property (
		is_single
			|=> last_r == $past(last_r))
		else $error("single clear changed tracker");

	AST_TRACK_FIRST: assert property (
		is_first
			|=> last_r == WDCL_LAST_FIRST)
		else $error("tracker lost first half");

	AST_ARM_ONLY: assert property (
		(last_r == WDCL_LAST_NONE && (is_first || is_second))
			|=> !clear_done_r)
		else $error("half-clear after reset cleared");

	AST_FLAGS_CLEARED: assert property (
		(is_single && !timeout_set && !powerdown_set)
			|=> !timeout_flag_r && !powerdown_flag_r)
		else $error("clear left a flag set");

	AST_SET_BEATS_CLEAR: assert property (
		(is_single && timeout_set && powerdown_set)
			|=> timeout_flag_r && powerdown_flag_r)
		else $error("set lost against clear");

	COV_SINGLE: cover property (is_single ##1 clear_done_r);
	COV_PAIR: cover property (is_first ##1 is_second ##1 clear_done_r);
	COV_REPEAT: cover property (is_first ##1 is_first ##1 !clear_done_r);
	COV_SET_WINS: cover property ((clear_nxt && timeout_set) ##1 timeout_flag_r);
	COV_REPEAT_SECOND: cover property (is_second ##1 is_second ##1 !clear_done_r);
endmodule : wdcl_clear_logic

// ---- dv/wdcl_decoder_model.sv ----
`timescale 1ns/1ps
module wdcl_decoder_model
(
	clk,
	cmd
);
	import wdcl_pkg::*;
	input wire logic clk;
	output wdcl_pkg::wdcl_cmd_s cmd;
	initial cmd = '0;
	// drives one op for one cycle, caller sits just after an edge
	task automatic issue(input wdcl_op_e op, input logic v);
		cmd = '{v, op};
		@(posedge clk);
		#1;
	endtask : issue
endmodule : wdcl_decoder_model

// ---- dv/test_watchdog_clear_instruction_logic.sv ----
`timescale 1ns/1ps
`include "wdcl_params.svh"
module test_watchdog_clear_instruction_logic;
	import wdcl_pkg::*;
	logic clk = 0, resetn = 0, tick = 0, tset = 0, pset = 0;
	wdcl_cmd_s cmd;
	logic [`WDCL_CNT_W-1:0] cnt_o;
	logic tf_o, pf_o, done_o;
	int n_mismatch = 0, n_checks = 0, cyc = 0, c;
	int m_cnt, m_tf, m_pf, m_done, m_last;
	wdcl_op_e seq[8] = '{WDCL_OP_SECOND, WDCL_OP_FIRST, WDCL_OP_FIRST, WDCL_OP_SECOND,
		WDCL_OP_SECOND, WDCL_OP_FIRST, WDCL_OP_SINGLE, WDCL_OP_SECOND};
	always #50 clk = ~clk;
	wdcl_decoder_model dec (.clk(clk), .cmd(cmd));
	wdcl_clear_logic dut (.clk(clk), .resetn(resetn), .cmd(cmd), .count_tick(tick), .timeout_set(tset),
		.powerdown_set(pset), .watchdog_counter_r(cnt_o), .timeout_flag_r(tf_o), .powerdown_flag_r(pf_o),
		.clear_done_r(done_o));
	// reference model, one step per edge
	always @(posedge clk or negedge resetn)
		if (!resetn)
		begin
			{m_cnt, m_tf, m_pf, m_done, m_last} = '0;
		end
		else
		begin
			c = cmd.valid && (cmd.op == WDCL_OP_SINGLE || cmd.op == WDCL_OP_FIRST && m_last == 2
				|| cmd.op == WDCL_OP_SECOND && m_last == 1);
			if (cmd.valid && cmd.op == WDCL_OP_FIRST) m_last = 1;
			if (cmd.valid && cmd.op == WDCL_OP_SECOND) m_last = 2;
			m_cnt = c ? 0 : (m_cnt + tick) % 256;
			m_tf = tset ? 1 : c ? 0 : m_tf;
			m_pf = pset ? 1 : c ? 0 : m_pf;
			m_done = c;
		end
	task chk_cnt(input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value counter exp %0h got %0h", e, g);
		end
	endtask : chk_cnt
	task chk_bit(input string nm, input logic e, input logic g);
		n_checks++;
		if (g !== e)
		begin
			n_mismatch++;
			$display("wrong value %s exp %0h got %0h", nm, e, g);
		end
	endtask : chk_bit
	task final_report;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : final_report
	always @(negedge clk)
	begin
		if (resetn)
		begin
			chk_cnt(8'(m_cnt), cnt_o);
			chk_bit("timeout", 1'(m_tf), tf_o);
			chk_bit("powerdown", 1'(m_pf), pf_o);
			chk_bit("done", 1'(m_done), done_o);
		end
		cyc++;
		if (cyc > 1500)
		begin
			n_mismatch++;
			final_report;
		end
	end
	initial
	begin
		void'($urandom(40));
		repeat (5) @(posedge clk);
		#1 resetn = 1;
		foreach (seq[i])
		begin
			tick = 1;
			tset = (i == 0);
			pset = (i == 0);
			dec.issue(seq[i], 1);
		end
		for (int i = 0; i < 800; i++)
		begin
			resetn = (i != 400);
			tick = $urandom % 2;
			tset = ($urandom % 6 == 0);
			pset = ($urandom % 6 == 0);
			dec.issue(wdcl_op_e'($urandom % 4), 1'($urandom % 3 != 0));
		end
		final_report;
	end
endmodule : test_watchdog_clear_instruction_logic
